//--- design/dual_timer_pkg.sv
// Shared constants, types and field layouts for the down-counting timer block.
package dual_timer_pkg;

  // Timer slots and count.
  localparam int          TIMER_COUNT    = 5;
  localparam int          WIDE_COUNT     = 2;
  localparam logic [2:0]  TMR_X          = 3'h0;
  localparam logic [2:0]  TMR_Y          = 3'h1;

  // Oscillator prescale: the timers count the oscillator divided by 16.
  localparam int          OSC_DIVIDE     = 16;
  localparam int          PRESC_W        = $clog2(OSC_DIVIDE);
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(OSC_DIVIDE - 1);

  // Reset values.
  localparam logic [15:0] CNT_RST        = 16'hFFFF;
  localparam logic [15:0] LATCH_RST      = 16'hFFFF;
  localparam logic [7:0]  BYTE_RST       = 8'h00;
  localparam logic [1:0]  RT_RST         = 2'h0;

  // Timer X modes, Gray coded along interval, pulse, event, width.
  typedef enum logic [1:0] {
    MODE_INTERVAL = 2'h0,
    MODE_PULSE    = 2'h1,
    MODE_EVENT    = 2'h3,
    MODE_WIDTH    = 2'h2
  } timer_x_mode_t;

  // One byte access from the processor side.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] sel;
    logic       hi;
    logic [7:0] data;
  } byte_access_t;

  // Timer X configuration bits.
  typedef struct packed {
    timer_x_mode_t mode;
    logic          latch_only;
    logic          edge_sel;
    logic          rt_enable;
    logic [1:0]    rt_data;
  } timer_x_cfg_t;

endpackage

//--- design/dual_timer_block.sv
// Five down-counting timers with timer X modes, pin edge request and real-time port.
module dual_timer_block
  import dual_timer_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          arst_n,
  input  wire logic          main_osc_input,
  input  wire logic          sub_osc_input,
  input  wire logic          low_speed,
  input  byte_access_t       acc,
  input  timer_x_cfg_t       cfg,
  input  wire logic          timer_x_pin_i,
  output logic [7:0]         rdata,
  output logic               timer_x_pin_o,
  output logic               timer_x_pin_oe,
  output logic               timer_x_pin_irq,
  output logic [TIMER_COUNT-1:0] timer_irq,
  output logic               realtime_out_bit_a,
  output logic               realtime_out_bit_b
);

  logic [15:0]        cnt_reg   [TIMER_COUNT];
  logic [15:0]        cnt_next  [TIMER_COUNT];
  logic [15:0]        latch_reg [TIMER_COUNT];
  logic [15:0]        latch_next[TIMER_COUNT];
  logic [TIMER_COUNT-1:0] count_en;
  logic [TIMER_COUNT-1:0] uflow;
  logic [7:0]         wtemp_reg, wtemp_next;
  logic [7:0]         rd_hold_reg, rd_hold_next;
  logic [7:0]         rdata_reg, rdata_next;
  logic               osc_prev_reg, osc_prev_next;
  logic [PRESC_W-1:0] presc_reg, presc_next;
  logic               osc_sel, tick;
  logic               pin_prev_reg, pin_prev_next;
  logic               x_edge;
  logic               pin_o_reg, pin_o_next;
  logic               pin_oe_reg, pin_oe_next;
  logic               pin_irq_reg, pin_irq_next;
  logic [TIMER_COUNT-1:0] irq_reg, irq_next;
  logic               rt_prev_en_reg, rt_prev_en_next;
  logic               rt_dirty_reg, rt_dirty_next;
  logic [1:0]         rt_data_prev_reg, rt_data_prev_next;
  logic [1:0]         rt_out_reg, rt_out_next;
  logic               rt_fire;

  // Prescaler: a rising edge of the selected oscillator advances it; wrap gives a tick.
  always_comb begin
    osc_sel       = low_speed ? sub_osc_input : main_osc_input;
    osc_prev_next = osc_sel;
    presc_next    = presc_reg;
    tick          = 1'b0;
    if (osc_sel && !osc_prev_reg) begin
      presc_next = presc_reg + PRESC_W'(1);
      tick       = (presc_reg == PRESC_LAST);
    end
  end

  // Pin edge detection; the active edge comes from the edge-select bit.
  always_comb begin
    pin_prev_next = timer_x_pin_i;
    x_edge        = cfg.edge_sel ? (pin_prev_reg && !timer_x_pin_i)
                                 : (!pin_prev_reg && timer_x_pin_i);
    pin_irq_next  = x_edge;
  end

  // Count source per timer; only timer X has modes.
  always_comb begin
    count_en = {TIMER_COUNT{tick}};
    unique case (cfg.mode)
      MODE_INTERVAL: count_en[TMR_X] = tick;
      MODE_PULSE:    count_en[TMR_X] = tick;
      MODE_EVENT:    count_en[TMR_X] = x_edge;
      MODE_WIDTH:    count_en[TMR_X] = tick && (timer_x_pin_i == !cfg.edge_sel);
    endcase
  end

  // Counters, latches and byte writes. The lower byte waits in wtemp until the
  // upper byte arrives, so a 16-bit value is never loaded half written.
  always_comb begin
    wtemp_next = wtemp_reg;
    for (int i = 0; i < TIMER_COUNT; i++) begin
      cnt_next[i]   = cnt_reg[i];
      latch_next[i] = latch_reg[i];
      uflow[i]      = 1'b0;
      if (count_en[i]) begin
        if (cnt_reg[i] == 16'h0000) begin
          uflow[i]    = 1'b1;
          cnt_next[i] = latch_reg[i];
        end else begin
          cnt_next[i] = cnt_reg[i] - 16'h0001;
        end
      end
      if (acc.wr && acc.sel == 3'(i)) begin
        if (i < WIDE_COUNT) begin
          if (!acc.hi) begin
            wtemp_next = acc.data;
          end else begin
            latch_next[i] = {acc.data, wtemp_reg};
            // Latch-only write leaves the counter alone; if an underflow lands
            // in this cycle the counter reloads the old latch value.
            if (!(i == int'(TMR_X) && cfg.latch_only)) begin
              cnt_next[i] = {acc.data, wtemp_reg};
            end
          end
        end else begin
          latch_next[i] = {8'h00, acc.data};
          cnt_next[i]   = {8'h00, acc.data};
        end
      end
    end
  end

  // Reads: an upper read captures the lower byte so the next lower read matches.
  always_comb begin
    rdata_next   = rdata_reg;
    rd_hold_next = rd_hold_reg;
    if (acc.rd) begin
      if (acc.sel < 3'(WIDE_COUNT)) begin
        if (acc.hi) begin
          rdata_next   = cnt_reg[acc.sel][15:8];
          rd_hold_next = cnt_reg[acc.sel][7:0];
        end else begin
          rdata_next = rd_hold_reg;
        end
      end else if (acc.sel < 3'(TIMER_COUNT)) begin
        rdata_next = cnt_reg[acc.sel][7:0];
      end else begin
        rdata_next = BYTE_RST;
      end
    end
  end

  // Pin output, request pulses.
  always_comb begin
    pin_oe_next = (cfg.mode == MODE_PULSE);
    pin_o_next  = pin_o_reg ^ (uflow[TMR_X] && cfg.mode == MODE_PULSE);
    irq_next    = uflow;
  end

  // Real-time port. The dirty flag remembers a rewrite so that enabling the
  // port can drive it at once; while enabled, new data waits for an underflow.
  always_comb begin
    rt_prev_en_next   = cfg.rt_enable;
    rt_data_prev_next = cfg.rt_data;
    rt_fire = cfg.rt_enable && (uflow[TMR_X] || (!rt_prev_en_reg && rt_dirty_reg));
    rt_out_next   = rt_fire ? cfg.rt_data : rt_out_reg;
    rt_dirty_next = rt_fire ? 1'b0 : rt_dirty_reg;
    // A rewrite in the same cycle as a drive still marks the data dirty.
    if (cfg.rt_data != rt_data_prev_reg) begin
      rt_dirty_next = 1'b1;
    end
  end

  // State registers.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < TIMER_COUNT; i++) begin
        cnt_reg[i]   <= CNT_RST;
        latch_reg[i] <= LATCH_RST;
      end
      wtemp_reg        <= BYTE_RST;
      rd_hold_reg      <= BYTE_RST;
      rdata_reg        <= BYTE_RST;
      osc_prev_reg     <= 1'b0;
      presc_reg        <= '0;
      pin_prev_reg     <= 1'b0;
      pin_o_reg        <= 1'b0;
      pin_oe_reg       <= 1'b0;
      pin_irq_reg      <= 1'b0;
      irq_reg          <= '0;
      rt_prev_en_reg   <= 1'b0;
      rt_dirty_reg     <= 1'b0;
      rt_data_prev_reg <= RT_RST;
      rt_out_reg       <= RT_RST;
    end else begin
      for (int i = 0; i < TIMER_COUNT; i++) begin
        cnt_reg[i]   <= cnt_next[i];
        latch_reg[i] <= latch_next[i];
      end
      wtemp_reg        <= wtemp_next;
      rd_hold_reg      <= rd_hold_next;
      rdata_reg        <= rdata_next;
      osc_prev_reg     <= osc_prev_next;
      presc_reg        <= presc_next;
      pin_prev_reg     <= pin_prev_next;
      pin_o_reg        <= pin_o_next;
      pin_oe_reg       <= pin_oe_next;
      pin_irq_reg      <= pin_irq_next;
      irq_reg          <= irq_next;
      rt_prev_en_reg   <= rt_prev_en_next;
      rt_dirty_reg     <= rt_dirty_next;
      rt_data_prev_reg <= rt_data_prev_next;
      rt_out_reg       <= rt_out_next;
    end
  end

  // Outputs straight from flip-flops.
  assign rdata              = rdata_reg;
  assign timer_x_pin_o      = pin_o_reg;
  assign timer_x_pin_oe     = pin_oe_reg;
  assign timer_x_pin_irq    = pin_irq_reg;
  assign timer_irq          = irq_reg;
  assign realtime_out_bit_a = rt_out_reg[0];
  assign realtime_out_bit_b = rt_out_reg[1];

  // Checks on the timer behaviour.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  logic wr_x;
  assign wr_x = acc.wr && acc.sel == TMR_X;

  sequence s_rt_arm;
    cfg.rt_enable && !rt_prev_en_reg && rt_dirty_reg;
  endsequence

  sequence s_hi_read_wide;
    acc.rd && acc.hi && acc.sel < 3'(WIDE_COUNT);
  endsequence

  // Lower read of the same timer after one quiet cycle, as software spaces byte reads.
  sequence s_lo_read_after;
    !acc.rd ##1 (acc.rd && !acc.hi && acc.sel == $past(acc.sel, 2));
  endsequence

  a_x_reload_zero: assert property (
    count_en[TMR_X] && cnt_reg[TMR_X] == 16'h0000 && !wr_x
    |=> cnt_reg[TMR_X] == $past(latch_reg[TMR_X]))
    else $error("Timer X did not reload from its latch.");

  a_irq_on_uflow: assert property (
    uflow[TMR_X] |=> timer_irq[TMR_X])
    else $error("Timer X underflow gave no request.");

  a_irq_cause_y: assert property (
    timer_irq[TMR_Y] |-> $past(cnt_reg[TMR_Y]) == 16'h0000 && $past(count_en[TMR_Y]))
    else $error("Timer Y request without underflow.");

  a_pulse_toggle: assert property (
    cfg.mode == MODE_PULSE && uflow[TMR_X]
    |=> timer_x_pin_o != $past(timer_x_pin_o))
    else $error("Pulse output did not toggle.");

  a_width_gate: assert property (
    cfg.mode == MODE_WIDTH && timer_x_pin_i == cfg.edge_sel && !wr_x
    |=> $stable(cnt_reg[TMR_X]))
    else $error("Width mode counted with the pin inactive.");

  a_direct_write: assert property (
    wr_x && acc.hi && !cfg.latch_only
    |=> cnt_reg[TMR_X] == {$past(acc.data), $past(wtemp_reg)}
        && latch_reg[TMR_X] == cnt_reg[TMR_X])
    else $error("Direct write missed counter or latch.");

  a_latch_only: assert property (
    wr_x && acc.hi && cfg.latch_only && !count_en[TMR_X]
    |=> $stable(cnt_reg[TMR_X]) && latch_reg[TMR_X] == {$past(acc.data), $past(wtemp_reg)})
    else $error("Latch-only write touched the counter.");

  a_edge_request: assert property (
    cfg.edge_sel == 1'b0 && !pin_prev_reg && timer_x_pin_i ##1 cfg.edge_sel == 1'b0
    |-> timer_x_pin_irq)
    else $error("Rising pin edge gave no request.");

  a_rt_immediate: assert property (
    s_rt_arm |=> {realtime_out_bit_b, realtime_out_bit_a} == $past(cfg.rt_data))
    else $error("Real-time data not driven on enable.");

  a_rt_hold: assert property (
    cfg.rt_enable && rt_prev_en_reg && !uflow[TMR_X]
    |=> $stable({realtime_out_bit_b, realtime_out_bit_a}))
    else $error("Real-time port changed without underflow.");

  a_coherent_read: assert property (
    s_hi_read_wide ##1 s_lo_read_after
    |=> rdata == $past(cnt_reg[acc.sel][7:0], 3))
    else $error("Lower byte read not coherent with upper.");

endmodule

//--- verification/osc_pin_model.sv
// Oscillator sources and timer pin driver that sit outside the timer block.
module osc_pin_model (
  input  wire logic mclk,
  input  wire logic run,
  input  wire logic pin_drv,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output wire logic main_osc_input,
  output wire logic sub_osc_input,
  output wire logic timer_x_pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic half_reg = 1'b0;
  // Both oscillators freeze while stopped, so register tests see no stray count.
  logic main_reg = 1'b0;
  logic sub_reg = 1'b0;
  // Main toggles each cycle; the sub oscillator runs at half that rate.
  always @(posedge mclk) begin
    if (run) begin
      main_reg <= ~main_reg;
      half_reg <= ~half_reg;
      if (half_reg) sub_reg <= ~sub_reg;
    end
  end
  assign main_osc_input = main_reg;
  assign sub_osc_input = sub_reg;
  // The far side drives the pin only while the block leaves it as an input.
  assign timer_x_pin_i = pin_oe ? pin_o : pin_drv;
endmodule

//--- verification/testbench.sv
// Self-checking bench for the five-timer block with a read-result scoreboard.
module testbench
  import dual_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic low_speed = 1'b0;
  logic run = 1'b0;
  logic pin_drv = 1'b0;
  logic rd_d = 1'b0;
  byte_access_t acc = '0;
  timer_x_cfg_t cfg = '0;
  logic main_osc_input, sub_osc_input, timer_x_pin_i, timer_x_pin_o, timer_x_pin_oe;
  logic timer_x_pin_irq, realtime_out_bit_a, realtime_out_bit_b;
  logic [7:0] rdata;
  logic [TIMER_COUNT-1:0] timer_irq;
  logic [7:0] exp_q[$];
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  int np = 0;
  int cnt[5] = '{default: 0};
  int last[5] = '{default: 0};
  int gap[5] = '{default: 0};

  always #2.5 mclk = ~mclk;

  dual_timer_block u_dut (.mclk(mclk), .arst_n(arst_n), .main_osc_input(main_osc_input),
    .sub_osc_input(sub_osc_input), .low_speed(low_speed), .acc(acc), .cfg(cfg),
    .timer_x_pin_i(timer_x_pin_i), .rdata(rdata), .timer_x_pin_o(timer_x_pin_o),
    .timer_x_pin_oe(timer_x_pin_oe), .timer_x_pin_irq(timer_x_pin_irq),
    .timer_irq(timer_irq), .realtime_out_bit_a(realtime_out_bit_a),
    .realtime_out_bit_b(realtime_out_bit_b));
  osc_pin_model u_far (.mclk(mclk), .run(run), .pin_drv(pin_drv), .pin_o(timer_x_pin_o),
    .pin_oe(timer_x_pin_oe), .main_osc_input(main_osc_input),
    .sub_osc_input(sub_osc_input), .timer_x_pin_i(timer_x_pin_i));

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done;
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Monitor: stamps interrupt pulses and scores read data one cycle after each read.
  always @(posedge mclk) begin
    cyc++;
    if (timer_x_pin_irq === 1'b1) np++;
    for (int k = 0; k < 5; k++) if (timer_irq[k] === 1'b1) begin
      gap[k] = cyc - last[k];
      last[k] = cyc;
      cnt[k]++;
    end
    if (rd_d) chk({8'h00, rdata}, {8'h00, exp_q.pop_front()});
    rd_d = acc.rd;
  end

  // One strobed byte access; the idle cycle after it keeps strobes apart.
  task acc_op(input logic w, input logic [2:0] s, input logic h, input logic [7:0] d);
    @(posedge mclk);
    acc <= '{wr: w, rd: !w, sel: s, hi: h, data: d};
    @(posedge mclk);
    acc <= '0;
  endtask

  // Low byte goes first so the upper write moves the whole word.
  task wr16(input logic [2:0] s, input logic [15:0] v);
    acc_op(1'b1, s, 1'b0, v[7:0]);
    acc_op(1'b1, s, 1'b1, v[15:8]);
  endtask

  // Upper byte first; never interleaved with a write sequence.
  task rd16(input logic [2:0] s, input logic [15:0] v);
    exp_q.push_back(v[15:8]);
    acc_op(1'b0, s, 1'b1, 8'h00);
    exp_q.push_back(v[7:0]);
    acc_op(1'b0, s, 1'b0, 8'h00);
  endtask

  task wait_irq(input int k, input int n);
    int c0;
    int t;
    c0 = cnt[k];
    t = 0;
    while (cnt[k] < c0 + n && t < 3000) begin
      @(posedge mclk);
      t++;
    end
    chk(16'(t < 3000), 16'h0001);
  endtask

  task cw(input int n);
    repeat (n) @(posedge mclk);
  endtask

  initial begin
    repeat (30000) @(posedge mclk);
    mismatches++;
    test_done();
  end

  initial begin
    logic [15:0] v;
    int b;
    int bp;
    void'($urandom(70));
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    // Round trip on every timer with stopped oscillators; sel 5 is unmapped.
    for (int s = 0; s < 6; s++) begin
      v = 16'($urandom);
      if (s < 2) begin
        wr16(3'(s), v);
        rd16(3'(s), v);
      end else begin
        acc_op(1'b1, 3'(s), 1'b0, v[7:0]);
        exp_q.push_back(s < 5 ? v[7:0] : 8'h00);
        acc_op(1'b0, 3'(s), 1'b0, 8'h00);
      end
    end
    // Latch-only write leaves the counter alone until the next underflow.
    wr16(3'h0, 16'h0004);
    cfg.latch_only <= 1'b1;
    wr16(3'h0, 16'h0002);
    rd16(3'h0, 16'h0004);
    wr16(3'h1, 16'h0001);
    acc_op(1'b1, 3'h2, 1'b0, 8'h03);
    run <= 1'b1;
    wait_irq(0, 2);
    chk(16'(gap[0]), 16'h0060);
    wait_irq(2, 2);
    chk(16'(gap[1]), 16'h0040);
    chk(16'(gap[2]), 16'h0080);
    low_speed <= 1'b1;
    wait_irq(0, 2);
    chk(16'(gap[0]), 16'h00C0);
    low_speed <= 1'b0;
    // Pulse output: the pin is driven and flips once per underflow.
    cfg.mode <= MODE_PULSE;
    wait_irq(0, 1);
    cw(2);
    v = 16'(timer_x_pin_o);
    chk(16'(timer_x_pin_oe), 16'h0001);
    wait_irq(0, 1);
    cw(2);
    chk(16'(timer_x_pin_o), {15'h0000, ~v[0]});
    // Event counting on both edge selections; only the active edge counts.
    run <= 1'b0;
    cfg.mode <= MODE_EVENT;
    cfg.latch_only <= 1'b0;
    for (int e = 0; e < 2; e++) begin
      cfg.edge_sel <= e[0];
      pin_drv <= e[0];
      cw(4);
      wr16(3'h0, 16'h0001);
      cw(2);
      b = np;
      bp = cnt[0];
      repeat (2) begin
        pin_drv <= !e[0];
        cw(3);
        pin_drv <= e[0];
        cw(3);
      end
      chk(16'(np - b), 16'h0002);
      chk(16'(cnt[0] - bp), 16'h0001);
    end
    // Width mode holds the count while the pin sits at its idle level.
    cfg.mode <= MODE_WIDTH;
    cfg.edge_sel <= 1'b0;
    pin_drv <= 1'b0;
    cw(2);
    wr16(3'h0, 16'h0000);
    b = cnt[0];
    run <= 1'b1;
    cw(100);
    chk(16'(cnt[0] - b), 16'h0000);
    pin_drv <= 1'b1;
    wait_irq(0, 1);
    // Real-time port: immediate drive on enable, later changes wait for underflow.
    run <= 1'b0;
    cfg.mode <= MODE_INTERVAL;
    cfg.rt_data <= 2'h2;
    cw(3);
    cfg.rt_enable <= 1'b1;
    cw(3);
    chk({14'h0000, realtime_out_bit_b, realtime_out_bit_a}, 16'h0002);
    cfg.rt_data <= 2'h1;
    cw(5);
    chk({14'h0000, realtime_out_bit_b, realtime_out_bit_a}, 16'h0002);
    wr16(3'h0, 16'h0001);
    run <= 1'b1;
    wait_irq(0, 1);
    cw(2);
    chk({14'h0000, realtime_out_bit_b, realtime_out_bit_a}, 16'h0001);
    test_done();
  end
endmodule
